// ### rtl/hsir_pkg.sv
// Package: register map, field positions and reset values of the HDLC/slip interrupt block
package hsir_pkg;
  localparam logic [11:0] hsir_dl_status_addr = 12'h000;
  localparam logic [11:0] hsir_dl_irq_enable_addr = 12'h004;
  localparam logic [11:0] hsir_slip_status_addr = 12'h008;
  localparam int hsir_idle_bit = 0;
  localparam int hsir_abort_bit = 1;
  localparam int hsir_check_bit = 2;
  localparam int hsir_slip_bit = 5;
  localparam int hsir_empty_bit = 6;
  localparam int hsir_full_bit = 7;
  localparam logic [7:0] hsir_enable_reset = 8'h00;
  localparam logic [7:0] hsir_enable_mask = 8'h07;
  localparam logic [7:0] hsir_status_reset = 8'h00;
  localparam logic [7:0] hsir_idle_octet = 8'h7E;
  localparam int hsir_abort_ones = 7;
  localparam logic [1:0] hsir_resp_okay = 2'h0;
  localparam logic [1:0] hsir_resp_slverr = 2'h2;
endpackage

// ### rtl/hsir_slip_ctrl.sv
// Transmit slip buffer occupancy tracker: delete on full write, repeat on empty read
`timescale 1ns/1ps
module hsir_slip_ctrl #(
  parameter int frame_words = 24,
  parameter int depth_frames = 2
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic frame_deleted,
  output logic frame_repeated,
  output logic buf_full,
  output logic buf_empty
);
  localparam int max_words = frame_words * depth_frames;
  localparam int cw = $clog2(max_words + 1);
  localparam logic [cw-1:0] fw = cw'(frame_words);
  localparam logic [cw-1:0] mw = cw'(max_words);
  logic [cw-1:0] level;

  assign buf_full = (level == mw);
  assign buf_empty = (level == '0);

  // Full write drops one frame; empty read replays one frame
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level <= '0;
      frame_deleted <= 1'b0;
      frame_repeated <= 1'b0;
    end else begin
      frame_deleted <= wr_strobe && buf_full; // [RQ4]
      frame_repeated <= rd_strobe && buf_empty; // [RQ5]
      if (wr_strobe && buf_full) begin
        level <= level - fw + cw'(rd_strobe ? 0 : 1);
      end else if (rd_strobe && buf_empty) begin
        level <= fw - cw'(wr_strobe ? 0 : 1);
      end else if (wr_strobe && !rd_strobe) begin
        level <= level + cw'(1);
      end else if (rd_strobe && !wr_strobe) begin
        level <= level - cw'(1);
      end
    end
  end
endmodule // hsir_slip_ctrl

// ### rtl/hsir_top.sv
// Top: HDLC receive interrupt enables, status flags and transmit slip status over AXI4-Lite
//
// Notes on behaviour
// RQ1 - Check-error enable bit 2 gates its interrupt
// RQ2 - Abort enable bit 1 gates seven-ones interrupt
// RQ3 - Idle enable bit 0 gates 0x7E flag interrupt
// RQ4 - Write when full deletes frame, sets bit 7
// RQ5 - Read when empty repeats frame, sets bit 6
// RQ6 - Slip bit 5 set on delete or repeat
// RQ7 - Slip flags held until status read, zero reset
// RQ8 - Software reads full/empty to tell slip cause
// RQ9 - Link status flags bits 2..0, clear on read
// RQ10 - Interrupt when any enabled flag is set
`timescale 1ns/1ps
module hsir_top #(
  parameter int frame_words = 24,
  parameter int depth_frames = 2
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_check_error,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic tx_slip_write,
  input wire logic tx_slip_read,
  output logic irq,
  output logic tx_slip_full,
  output logic tx_slip_empty
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] data_link_irq_enable;
  logic [7:0] data_link_status;
  logic [7:0] slip_buffer_irq_status;
  logic [7:0] shift;
  logic [3:0] ones_run;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic rd_dl_status;
  logic rd_slip_status;
  logic abort_seen;
  logic flag_seen;
  logic deleted;
  logic repeated;
  logic full_now;
  logic empty_now;
  logic [7:0] next_shift;

  function automatic logic hsir_hit(input logic [11:0] a, input logic [11:0] r);
    return a[11:2] == r[11:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hsir_pkg::hsir_resp_okay;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        if (hsir_hit(aw_addr, hsir_pkg::hsir_dl_irq_enable_addr) ||
            hsir_hit(aw_addr, hsir_pkg::hsir_dl_status_addr) ||
            hsir_hit(aw_addr, hsir_pkg::hsir_slip_status_addr)) begin
          s_axi_bresp <= hsir_pkg::hsir_resp_okay;
        end else begin
          s_axi_bresp <= hsir_pkg::hsir_resp_slverr;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel; a taken read of a status register clears it
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rd_dl_status = do_read && hsir_hit(s_axi_araddr, hsir_pkg::hsir_dl_status_addr);
  assign rd_slip_status = do_read && hsir_hit(s_axi_araddr, hsir_pkg::hsir_slip_status_addr);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= hsir_pkg::hsir_resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= hsir_pkg::hsir_resp_okay;
        if (hsir_hit(s_axi_araddr, hsir_pkg::hsir_dl_irq_enable_addr)) begin
          s_axi_rdata <= {24'h000000, data_link_irq_enable};
        end else if (hsir_hit(s_axi_araddr, hsir_pkg::hsir_dl_status_addr)) begin
          s_axi_rdata <= {24'h000000, data_link_status};
        end else if (hsir_hit(s_axi_araddr, hsir_pkg::hsir_slip_status_addr)) begin
          s_axi_rdata <= {24'h000000, slip_buffer_irq_status};
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= hsir_pkg::hsir_resp_slverr;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable register, writable low three bits only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_link_irq_enable <= hsir_pkg::hsir_enable_reset;
    end else if (do_write && w_strb[0] &&
                 hsir_hit(aw_addr, hsir_pkg::hsir_dl_irq_enable_addr)) begin
      data_link_irq_enable <= w_data[7:0] & hsir_pkg::hsir_enable_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive data link monitor: seven ones for abort, flag octet for idle
  assign next_shift = {rx_bit, shift[7:1]};
  assign abort_seen = rx_bit_valid && rx_bit &&
                      (ones_run == 4'(hsir_pkg::hsir_abort_ones - 1));
  assign flag_seen = rx_bit_valid && (next_shift == hsir_pkg::hsir_idle_octet);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift <= '0;
      ones_run <= '0;
    end else if (rx_bit_valid) begin
      shift <= next_shift;
      if (!rx_bit) begin
        ones_run <= '0;
      end else if (ones_run != 4'hF) begin
        ones_run <= ones_run + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched link status; a new event wins over the read clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_link_status <= hsir_pkg::hsir_status_reset;
    end else begin
      if (rd_dl_status) begin
        data_link_status <= hsir_pkg::hsir_status_reset; // [RQ9]
      end
      if (rx_check_error) begin
        data_link_status[hsir_pkg::hsir_check_bit] <= 1'b1; // [RQ9]
      end
      if (abort_seen) begin
        data_link_status[hsir_pkg::hsir_abort_bit] <= 1'b1; // [RQ9]
      end
      if (flag_seen) begin
        data_link_status[hsir_pkg::hsir_idle_bit] <= 1'b1; // [RQ9]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit slip buffer and its sticky status
  hsir_slip_ctrl #(
    .frame_words(frame_words),
    .depth_frames(depth_frames)
  ) u_slip (
    .mclk(mclk),
    .resetn(resetn),
    .wr_strobe(tx_slip_write),
    .rd_strobe(tx_slip_read),
    .frame_deleted(deleted),
    .frame_repeated(repeated),
    .buf_full(full_now),
    .buf_empty(empty_now)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slip_buffer_irq_status <= hsir_pkg::hsir_status_reset; // [RQ7]
      tx_slip_full <= 1'b0;
      tx_slip_empty <= 1'b1;
    end else begin
      tx_slip_full <= full_now;
      tx_slip_empty <= empty_now;
      if (rd_slip_status) begin
        slip_buffer_irq_status <= hsir_pkg::hsir_status_reset; // [RQ7]
      end
      if (deleted) begin
        slip_buffer_irq_status[hsir_pkg::hsir_full_bit] <= 1'b1; // [RQ4]
        slip_buffer_irq_status[hsir_pkg::hsir_slip_bit] <= 1'b1; // [RQ6]
      end
      if (repeated) begin
        slip_buffer_irq_status[hsir_pkg::hsir_empty_bit] <= 1'b1; // [RQ5]
        slip_buffer_irq_status[hsir_pkg::hsir_slip_bit] <= 1'b1; // [RQ6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request from enabled link flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (data_link_status[hsir_pkg::hsir_check_bit] &
              data_link_irq_enable[hsir_pkg::hsir_check_bit]) | // [RQ1] [RQ10]
             (data_link_status[hsir_pkg::hsir_abort_bit] &
              data_link_irq_enable[hsir_pkg::hsir_abort_bit]) | // [RQ2]
             (data_link_status[hsir_pkg::hsir_idle_bit] &
              data_link_irq_enable[hsir_pkg::hsir_idle_bit]); // [RQ3]
    end
  end
endmodule // hsir_top

// ### testbench/hsir_assertions.sv
// Checker: bus, interrupt and slip relations at the top ports
`timescale 1ns/1ps
module hsir_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_check_error,
  input wire logic rx_bit_valid,
  input wire logic tx_slip_write,
  input wire logic tx_slip_read,
  input wire logic irq,
  input wire logic tx_slip_full,
  input wire logic tx_slip_empty
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [2:0] since;
  // Cycles since the last event or register write that may raise the request
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) since <= 3'h7;
    else if (rx_check_error | rx_bit_valid | (s_axi_wvalid & s_axi_wready)) since <= 3'h0;
    else if (since != 3'h7) since <= since + 3'h1;
  end
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_irq_cause: assert property ($rose(irq) |-> since <= 3'h4)
    else $error("request without cause");
  a_full_delete: assert property (tx_slip_full && tx_slip_write |=> ##[0:2] !tx_slip_full)
    else $error("no frame deleted");
  a_empty_repeat: assert property (tx_slip_empty && tx_slip_read |=> ##[0:2] !tx_slip_empty)
    else $error("no frame repeated");
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_irq_up: cover property ($rose(irq));
  c_slip_delete: cover property (tx_slip_full && tx_slip_write);
endmodule // hsir_checker

// ### testbench/hsir_top_tb_top.sv
// Testbench: register access, link events and slip buffer scenarios
`timescale 1ns/1ps
module hsir_top_tb_top;
  logic mclk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rx_check_error, rx_bit_valid, rx_bit, tx_slip_write, tx_slip_read, irq;
  logic tx_slip_full, tx_slip_empty;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_mismatch, num_checks;
  localparam logic [11:0] a_ls = hsir_pkg::hsir_dl_status_addr;
  localparam logic [11:0] a_en = hsir_pkg::hsir_dl_irq_enable_addr;
  localparam logic [11:0] a_ss = hsir_pkg::hsir_slip_status_addr;
  hsir_top #(.frame_words(2), .depth_frames(2)) hsir_top_inst (.mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_check_error(rx_check_error),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .tx_slip_write(tx_slip_write),
    .tx_slip_read(tx_slip_read), .irq(irq), .tx_slip_full(tx_slip_full),
    .tx_slip_empty(tx_slip_empty));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bit ad;
    bit dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge mclk);
      ad = ad | (s_axi_awready === 1'b1);
      dd = dd | (s_axi_wready === 1'b1);
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge mclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge mclk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // One-cycle strobe: 0 check error, 1 slip write, 2 slip read
  task automatic ev(input int k);
    @(posedge mclk);
    rx_check_error <= (k == 0);
    tx_slip_write <= (k == 1);
    tx_slip_read <= (k == 2);
    @(posedge mclk);
    {rx_check_error, tx_slip_write, tx_slip_read} <= 3'h0;
  endtask
  task automatic bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_bit_valid <= 1'b1;
      rx_bit <= v[i];
    end
    @(posedge mclk);
    rx_bit_valid <= 1'b0;
  endtask
  // Event for link status bit j: flag octet, seven ones, check error
  task automatic fire(input int j);
    if (j == 2) ev(0);
    else bits(j == 1 ? 8'h7F : 8'h7E, j == 1 ? 7 : 8);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {rx_check_error, rx_bit_valid, rx_bit, tx_slip_write, tx_slip_read} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rd_reg(a_en); chk(rd, 32'h0);
    rd_reg(a_ss); chk(rd, 32'h0);
    chk(tx_slip_empty, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr_reg(a_en, 32'h1 << i, 4'h1);
      rd_reg(a_en); chk(rd, 32'h1 << i);
      for (int j = 0; j < 3; j++) if (j != i) fire(j);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      rd_reg(a_ls); chk(rd, 32'h7 & ~(32'h1 << i));
      fire(i);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b1);
      rd_reg(a_ls); chk(rd, 32'h1 << i);
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
    end
    wr_reg(a_en, 32'hFF, 4'hE);
    rd_reg(a_en); chk(rd, 32'h4);
    wr_reg(a_en, 32'hFF, 4'hF);
    rd_reg(a_en); chk(rd, 32'h7);
    wr_reg(12'hFFC, 32'h0, 4'hF); chk(rsp, hsir_pkg::hsir_resp_slverr);
    rd_reg(12'hFFC); chk(rsp, hsir_pkg::hsir_resp_slverr);
    wr_reg(a_ss, 32'hFF, 4'hF); chk(rsp, hsir_pkg::hsir_resp_okay);
    repeat (4) ev(1);
    repeat (2) @(posedge mclk);
    chk(tx_slip_full, 1'b1);
    rd_reg(a_ss); chk(rd, 32'h0);
    ev(1);
    repeat (4) @(posedge mclk);
    chk(tx_slip_full, 1'b0);
    rd_reg(a_ss); chk(rd, 32'hA0);
    rd_reg(a_ss); chk(rd, 32'h0);
    // A delete keeps the incoming word, so three words remain to drain
    repeat (3) ev(2);
    repeat (2) @(posedge mclk);
    chk(tx_slip_empty, 1'b1);
    ev(2);
    repeat (4) @(posedge mclk);
    chk(tx_slip_empty, 1'b0);
    rd_reg(a_ss); chk(rd, 32'h60);
    rd_reg(a_ss); chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule // hsir_top_tb_top
bind hsir_top hsir_checker hsir_checker_inst (.mclk(mclk), .resetn(resetn),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_check_error(rx_check_error),
  .rx_bit_valid(rx_bit_valid), .tx_slip_write(tx_slip_write), .tx_slip_read(tx_slip_read),
  .irq(irq), .tx_slip_full(tx_slip_full), .tx_slip_empty(tx_slip_empty));
